//--- mpp_cfg.svh
/*
 Constants for the port pin block: widths, reset values, masks and timing counts.
 Assumes it is included by its bare name from the design files of this block.
*/
// Function
// RULE1: Outside logic holds reset low over 2 us, longer for oscillator settling.
// RULE2: First bidirectional port has eight lines, each with its own direction bit.
// RULE3: Reset clears first port's direction bits, so every line is an input.
// RULE4: Second bidirectional port has the same direction control and reset behaviour; in code lines 7:6 stay outputs, also at reset.
// RULE5: Fourteen programmable lines: all of the first port, low six of the second.
// RULE6: First high-voltage port is eight output-only lines driven from a latch.
// RULE7: Second high-voltage port behaves like the first high-voltage port.
// RULE8: Four-line input-only port, readable by software, with no output drive.
// RULE9: One pin serves as external interrupt input or as sub-clock timer output.
// RULE10: Dedicated external interrupt pin is the lowest-priority external request.
// RULE11: Direction one drives the line from the latch; zero reads the pin.
`ifndef MPP_CFG_SVH
`define MPP_CFG_SVH

// ----------------------------------------------------------------
// Widths, reset values and masks
// ----------------------------------------------------------------
`define MPP_PORT_W     8
`define MPP_IN_W       4
`define MPP_SYNC_W     22
`define MPP_DIR_RST    8'h00
`define MPP_LAT_RST    8'h00
`define MPP_C_PROG     8'h3F
`define MPP_C_FIXED    8'hC0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MPP_CLK_NS     20
`define MPP_RST_MIN_NS 2000
`define MPP_RST_MIN_CYC ((`MPP_RST_MIN_NS + `MPP_CLK_NS - 1) / `MPP_CLK_NS)
`define MPP_RD_LAT     3

`endif

//--- mpp_pkg.sv
/*
 Types for the port pin block: write command, pin drive group, interrupt source.
 Assumes the CPU side writes on the same clock as the block.
*/
package mpp_pkg;

	// ----------------------------------------------------------------
	// Write targets of the CPU side
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MPP_SEL_A_DIR,
		MPP_SEL_A_LAT,
		MPP_SEL_B_LAT,
		MPP_SEL_C_DIR,
		MPP_SEL_C_LAT,
		MPP_SEL_D_LAT,
		MPP_SEL_MODE
	} mpp_sel_t;

	// One write, valid for a single cycle while en is high
	typedef struct packed {
		logic           en;
		mpp_sel_t       sel;
		logic [7:0]     data;
	} mpp_wr_t;

	// Drive of a two-way port: level and enable per line
	typedef struct packed {
		logic [7:0]     o;
		logic [7:0]     oe;
	} mpp_drv_t;

	// Interrupt request chosen for service
	typedef enum logic [1:0] {
		MPP_IRQ_NONE,
		MPP_IRQ_TMR_PIN,
		MPP_IRQ_LOW
	} mpp_irq_t;

endpackage

//--- mpp_sync.sv
/*
 Two flip-flop synchroniser for a bundle of pin levels.
 Assumes each bit is an independent level; no word coherence across bits.
*/
`timescale 1ns/1ns
module mpp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         sys_clk_in,
	input  wire logic         reset_n_in,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

//--- mpp_ports.sv
/*
 Port pin block: two bidirectional ports, two output-only ports, a four-line
 input port and two external interrupt pins, one shared with a timer output.
 Assumes CPU writes and interrupt acks come from logic on sys_clk_in; all pins
 are asynchronous and pass the synchroniser before use.
*/
`timescale 1ns/1ns
`include "mpp_cfg.svh"
module mpp_ports (
	// Clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             reset_n_in,
	// CPU side writes and interrupt service
	input  wire mpp_pkg::mpp_wr_t wr_in,
	input  wire logic [1:0]       irq_ack_in,
	input  wire logic             timer_sub_in,
	// Bidirectional ports
	input  wire logic [7:0]       bidir_port_a_in,
	output mpp_pkg::mpp_drv_t     bidir_port_a_out,
	input  wire logic [7:0]       bidir_port_c_in,
	output mpp_pkg::mpp_drv_t     bidir_port_c_out,
	// Output-only ports
	output logic [7:0]            hv_out_port_b_out,
	output logic [7:0]            hv_out_port_d_out,
	// Input-only port
	input  wire logic [3:0]       port_r_in,
	// Interrupt pins, both active low
	input  wire logic             ext_irq_low_prio_n_in,
	input  wire logic             ext_irq_or_timer_out_n_in,
	output logic                  ext_irq_or_timer_out_o_out,
	output logic                  ext_irq_or_timer_out_oe_out,
	// Read-back and interrupt status
	output logic [7:0]            port_a_rd_out,
	output logic [7:0]            port_c_rd_out,
	output logic [3:0]            port_r_rd_out,
	output logic [1:0]            irq_pend_out,
	output mpp_pkg::mpp_irq_t     irq_sel_out
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [`MPP_SYNC_W-1:0] sync_s;
	logic [7:0]             a_pin_s;
	logic [7:0]             c_pin_s;
	logic [3:0]             r_pin_s;
	logic                   low_n_s;
	logic                   shr_n_s;
	logic                   low_act_s;
	logic                   shr_act_s;

	// All pins share one synchroniser instance; interrupt pins enter inverted so the
	// synchroniser's cleared state is their idle level and no false edge follows reset
	mpp_sync #(.W(`MPP_SYNC_W)) u_sync (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.async_in   ({bidir_port_a_in, bidir_port_c_in, port_r_in,
		              ~ext_irq_low_prio_n_in, ~ext_irq_or_timer_out_n_in}),
		.sync_out   (sync_s)
	);

	assign {a_pin_s, c_pin_s, r_pin_s, low_act_s, shr_act_s} = sync_s;
	assign low_n_s = ~low_act_s;
	assign shr_n_s = ~shr_act_s;

	// ----------------------------------------------------------------
	// Direction and output latches
	// ----------------------------------------------------------------
	logic [7:0] a_dir_q;
	logic [7:0] a_lat_q;
	logic [7:0] b_lat_q;
	logic [5:0] c_dir_q;
	logic [7:0] c_lat_q;
	logic [7:0] d_lat_q;
	logic       tmr_mode_q;

	// Direction bits clear at reset so every programmable line starts as input
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			a_dir_q <= `MPP_DIR_RST; // [RULE3]
			c_dir_q <= 6'h00; // [RULE4]
		end else if (wr_in.en) begin
			if (wr_in.sel == mpp_pkg::MPP_SEL_A_DIR) begin
				a_dir_q <= wr_in.data; // [RULE2]
			end
			// Only the low six lines of port c take a direction
			if (wr_in.sel == mpp_pkg::MPP_SEL_C_DIR) begin
				c_dir_q <= wr_in.data[5:0]; // [RULE5]
			end
		end
	end

	// Output latches hold their value until the next write
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			a_lat_q <= `MPP_LAT_RST;
			b_lat_q <= `MPP_LAT_RST;
			c_lat_q <= `MPP_LAT_RST;
			d_lat_q <= `MPP_LAT_RST;
		end else if (wr_in.en) begin
			unique case (wr_in.sel)
				mpp_pkg::MPP_SEL_A_LAT: a_lat_q <= wr_in.data;
				mpp_pkg::MPP_SEL_B_LAT: b_lat_q <= wr_in.data; // [RULE6]
				mpp_pkg::MPP_SEL_C_LAT: c_lat_q <= wr_in.data;
				mpp_pkg::MPP_SEL_D_LAT: d_lat_q <= wr_in.data; // [RULE7]
				default: ;
			endcase
		end
	end

	// Shared pin mode: bit 0 set hands the pin to the timer
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tmr_mode_q <= 1'b0;
		end else if (wr_in.en && wr_in.sel == mpp_pkg::MPP_SEL_MODE) begin
			tmr_mode_q <= wr_in.data[0]; // [RULE9]
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Enable follows direction; upper port c lines are always outputs
	assign bidir_port_a_out.o  = a_lat_q;
	assign bidir_port_a_out.oe = a_dir_q; // [RULE11]
	assign bidir_port_c_out.o  = c_lat_q;
	assign bidir_port_c_out.oe = `MPP_C_FIXED | {2'b00, c_dir_q}; // [RULE5] [RULE11]
	assign hv_out_port_b_out   = b_lat_q; // [RULE6]
	assign hv_out_port_d_out   = d_lat_q; // [RULE7]

	// Timer output passes straight through; it is already on this clock
	assign ext_irq_or_timer_out_o_out  = timer_sub_in; // [RULE9]
	assign ext_irq_or_timer_out_oe_out = tmr_mode_q; // [RULE9]

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	logic [7:0] c_oe_s;
	logic [7:0] a_rd_d;
	logic [7:0] c_rd_d;

	assign c_oe_s = bidir_port_c_out.oe;

	// Per line: an output reads its latch, an input reads the pin
	for (genvar i = 0; i < `MPP_PORT_W; i++) begin : g_rd
		assign a_rd_d[i] = a_dir_q[i] ? a_lat_q[i] : a_pin_s[i]; // [RULE11]
		assign c_rd_d[i] = c_oe_s[i] ? c_lat_q[i] : c_pin_s[i]; // [RULE11]
	end

	// Registered so software sees a steady value for a whole cycle
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			port_a_rd_out <= 8'h00;
			port_c_rd_out <= 8'h00;
			port_r_rd_out <= 4'h0;
		end else begin
			port_a_rd_out <= a_rd_d;
			port_c_rd_out <= c_rd_d;
			port_r_rd_out <= r_pin_s; // [RULE8]
		end
	end

	// ----------------------------------------------------------------
	// External interrupts
	// ----------------------------------------------------------------
	logic low_prev_q;
	logic shr_prev_q;
	logic low_fall;
	logic shr_fall;

	// Previous levels; reset high like the synchroniser's idle output, so a pin held low at release is seen as an edge
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_prev_q <= 1'b1;
			shr_prev_q <= 1'b1;
		end else begin
			low_prev_q <= low_n_s;
			shr_prev_q <= shr_n_s;
		end
	end

	assign low_fall = low_prev_q & ~low_n_s;
	// In timer mode the pin is ours, so its own edges are not requests
	assign shr_fall = shr_prev_q & ~shr_n_s & ~tmr_mode_q; // [RULE9]

	// Sticky requests; a new edge wins over an ack in the same cycle
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_pend_out <= 2'b00;
		end else begin
			irq_pend_out[0] <= shr_fall | (irq_pend_out[0] & ~irq_ack_in[0]);
			irq_pend_out[1] <= low_fall | (irq_pend_out[1] & ~irq_ack_in[1]);
		end
	end

	// The dedicated pin is served only when the shared pin is quiet
	always_comb begin
		if (irq_pend_out[0]) begin
			irq_sel_out = mpp_pkg::MPP_IRQ_TMR_PIN;
		end else if (irq_pend_out[1]) begin
			irq_sel_out = mpp_pkg::MPP_IRQ_LOW; // [RULE10]
		end else begin
			irq_sel_out = mpp_pkg::MPP_IRQ_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	logic [1:0] age_q;
	logic       first_q;

	// Cycles since reset release, saturating, for checks only
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			age_q   <= 2'd0;
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
			if (age_q != 2'd3) begin
				age_q <= age_q + 2'd1;
			end
		end
	end

	property p_a_dir_write;
		wr_in.en && wr_in.sel == mpp_pkg::MPP_SEL_A_DIR |=> bidir_port_a_out.oe == $past(wr_in.data);
	endproperty
	a_a_dir_write: assert property (p_a_dir_write) else $error("port a enable missed dir write"); // [RULE2]

	property p_reset_inputs;
		first_q |-> bidir_port_a_out.oe == 8'h00 && bidir_port_c_out.oe[5:0] == 6'h00;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("line driven after reset"); // [RULE3]

	property p_c_dir_write;
		wr_in.en && wr_in.sel == mpp_pkg::MPP_SEL_C_DIR |=> bidir_port_c_out.oe[5:0] == $past(wr_in.data[5:0]);
	endproperty
	a_c_dir_write: assert property (p_c_dir_write) else $error("port c enable missed dir write"); // [RULE4]

	property p_c_upper_fixed;
		bidir_port_c_out.oe[7:6] == 2'b11 ##1 bidir_port_c_out.oe[7:6] == 2'b11;
	endproperty
	a_c_upper_fixed: assert property (p_c_upper_fixed) else $error("port c upper lines not output"); // [RULE5]

	property p_b_latch;
		wr_in.en && wr_in.sel == mpp_pkg::MPP_SEL_B_LAT |=> hv_out_port_b_out == $past(wr_in.data);
	endproperty
	a_b_latch: assert property (p_b_latch) else $error("port b latch not loaded"); // [RULE6]

	property p_d_hold;
		!(wr_in.en && wr_in.sel == mpp_pkg::MPP_SEL_D_LAT) |=> $stable(hv_out_port_d_out);
	endproperty
	a_d_hold: assert property (p_d_hold) else $error("port d changed without write"); // [RULE7]

	property p_r_read;
		age_q == 2'd3 |-> port_r_rd_out == $past(port_r_in, 3);
	endproperty
	a_r_read: assert property (p_r_read) else $error("port r read wrong"); // [RULE8]

	property p_timer_pin;
		tmr_mode_q |-> ext_irq_or_timer_out_oe_out && ext_irq_or_timer_out_o_out == timer_sub_in && !shr_fall;
	endproperty
	a_timer_pin: assert property (p_timer_pin) else $error("shared pin not timer output"); // [RULE9]

	property p_low_prio;
		irq_pend_out == 2'b11 |-> irq_sel_out == mpp_pkg::MPP_IRQ_TMR_PIN;
	endproperty
	a_low_prio: assert property (p_low_prio) else $error("low priority pin won"); // [RULE10]

	property p_a_read_latch;
		age_q == 2'd3 && a_dir_q == 8'hFF ##1 a_dir_q == 8'hFF |-> port_a_rd_out == $past(a_lat_q);
	endproperty
	a_a_read_latch: assert property (p_a_read_latch) else $error("output line read not latch"); // [RULE11]

	c_low_edge: cover property (low_fall ##1 irq_pend_out[1]);
	c_both_pend: cover property (irq_pend_out == 2'b11);
	c_timer_mode: cover property ($rose(tmr_mode_q));

endmodule

//--- mpp_board.sv
/*
 Board model for the port pin block: resolves each two-way line from the
 chip's drive and the board's own level.
 Assumes the board yields a line whenever the chip enables its driver.
*/
`timescale 1ns/1ns
module mpp_board (
	// Chip side drive
	input  wire mpp_pkg::mpp_drv_t a_drv_in,
	input  wire mpp_pkg::mpp_drv_t c_drv_in,
	input  wire logic              shr_o_in,
	input  wire logic              shr_oe_in,
	// Board side levels
	input  wire logic [7:0]        a_lvl_in,
	input  wire logic [7:0]        c_lvl_in,
	input  wire logic              shr_lvl_in,
	// Resolved wires
	output logic [7:0]             a_pin_out,
	output logic [7:0]             c_pin_out,
	output logic                   shr_pin_out
);
	// Board steps back on driven lines so no contention is modelled
	assign a_pin_out   = (a_drv_in.oe & a_drv_in.o) | (~a_drv_in.oe & a_lvl_in);
	assign c_pin_out   = (c_drv_in.oe & c_drv_in.o) | (~c_drv_in.oe & c_lvl_in);
	assign shr_pin_out = shr_oe_in ? shr_o_in : shr_lvl_in;
endmodule

//--- test_mpp_ports.sv
/*
 Self-checking bench for the port pin block with a board model on the pins.
 Assumes the block's constants and types from its package and header.
*/
`timescale 1ns/1ns
module test_mpp_ports;
	logic              sys_clk_in;
	logic              reset_n_in;
	mpp_pkg::mpp_wr_t  wr;
	mpp_pkg::mpp_drv_t a_drv, c_drv;
	mpp_pkg::mpp_irq_t sel;
	logic [1:0]        ack, pend;
	logic [7:0]        a_lvl, c_lvl, a_pin, c_pin, b_q, d_q, a_rd, c_rd;
	logic [7:0]        da, la, dc, lc;
	logic [3:0]        r_lvl, r_rd;
	logic              tmr, irq1_n, shr_lvl, shr_o, shr_oe, shr_pin;
	int                bad_count, comparisons, i;

	mpp_ports mpp_ports_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .wr_in(wr),
		.irq_ack_in(ack), .timer_sub_in(tmr), .bidir_port_a_in(a_pin), .bidir_port_a_out(a_drv),
		.bidir_port_c_in(c_pin), .bidir_port_c_out(c_drv), .hv_out_port_b_out(b_q),
		.hv_out_port_d_out(d_q), .port_r_in(r_lvl), .ext_irq_low_prio_n_in(irq1_n),
		.ext_irq_or_timer_out_n_in(shr_pin), .ext_irq_or_timer_out_o_out(shr_o),
		.ext_irq_or_timer_out_oe_out(shr_oe), .port_a_rd_out(a_rd), .port_c_rd_out(c_rd),
		.port_r_rd_out(r_rd), .irq_pend_out(pend), .irq_sel_out(sel));
	mpp_board mpp_board_i (.a_drv_in(a_drv), .c_drv_in(c_drv), .shr_o_in(shr_o), .shr_oe_in(shr_oe),
		.a_lvl_in(a_lvl), .c_lvl_in(c_lvl), .shr_lvl_in(shr_lvl), .a_pin_out(a_pin),
		.c_pin_out(c_pin), .shr_pin_out(shr_pin));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task step(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	// Leaves en high so writes can follow back to back
	task wr_t(input mpp_pkg::mpp_sel_t s, input logic [7:0] d);
		wr = '{1'b1, s, d};
		step(1);
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] rd_exp(input logic [7:0] lat, dir, pin);
		return (lat & dir) | (pin & ~dir);
	endfunction
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk_reset;
		chk({a_drv.oe, c_drv.oe}, 16'h00C0);
		chk({b_q, d_q}, 16'h0000);
		chk({a_drv.o, c_drv.o}, 16'h0000);
		chk({shr_oe, pend, sel}, {1'b0, 2'b00, mpp_pkg::MPP_IRQ_NONE});
	endtask

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		#100000;
		bad_count++;
		print_verdict;
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		reset_n_in = 1'b0;
		wr = '0;
		ack = 2'b00;
		tmr = 1'b0;
		a_lvl = 8'h00;
		c_lvl = 8'h00;
		r_lvl = 4'h0;
		irq1_n = 1'b1;
		shr_lvl = 1'b1;
		bad_count = 0;
		comparisons = 0;
		i = $urandom(32'h1f407f73);
		step(5);
		reset_n_in = 1'b1;
		chk_reset;
		$display("test reset done");
		// Output-only latches, written back to back
		for (i = 0; i < 8; i++) begin
			la = (i == 0) ? 8'hFF : 8'($urandom);
			lc = 8'($urandom);
			wr_t(mpp_pkg::MPP_SEL_B_LAT, la);
			wr_t(mpp_pkg::MPP_SEL_D_LAT, lc);
			chk(b_q, la);
			chk(d_q, lc);
		end
		// Drop the strobe and let an edge pass before the next write burst
		wr.en = 1'b0;
		step(1);
		$display("test latches done");
		// Two-way ports; first passes use all-input and all-output
		for (i = 0; i < 20; i++) begin
			da = (i < 2) ? {8{i[0]}} : 8'($urandom);
			dc = (i < 2) ? {8{i[0]}} : 8'($urandom);
			la = 8'($urandom);
			lc = 8'($urandom);
			a_lvl = 8'($urandom);
			c_lvl = 8'($urandom);
			r_lvl = 4'($urandom);
			tmr = 1'($urandom);
			wr_t(mpp_pkg::MPP_SEL_A_DIR, da);
			wr_t(mpp_pkg::MPP_SEL_A_LAT, la);
			wr_t(mpp_pkg::MPP_SEL_C_DIR, dc);
			wr_t(mpp_pkg::MPP_SEL_C_LAT, lc);
			wr.en = 1'b0;
			step(4);
			chk(a_drv, {la, da});
			chk(c_drv, {lc, 2'b11, dc[5:0]});
			chk(a_rd, rd_exp(la, da, a_lvl));
			chk(c_rd, rd_exp(lc, {2'b11, dc[5:0]}, c_lvl));
			chk(r_rd, r_lvl);
		end
		$display("test ports done");
		// Interrupt edges, priority and acknowledge
		irq1_n = 1'b0;
		step(4);
		chk({pend, sel}, {2'b10, mpp_pkg::MPP_IRQ_LOW});
		shr_lvl = 1'b0;
		step(4);
		chk({pend, sel}, {2'b11, mpp_pkg::MPP_IRQ_TMR_PIN});
		ack = 2'b01;
		step(1);
		chk({pend, sel}, {2'b10, mpp_pkg::MPP_IRQ_LOW});
		ack = 2'b10;
		step(1);
		ack = 2'b00;
		chk({pend, sel}, {2'b00, mpp_pkg::MPP_IRQ_NONE});
		irq1_n = 1'b1;
		shr_lvl = 1'b1;
		$display("test interrupts done");
		// Shared pin as timer output: drives the pin, edges ignored
		wr_t(mpp_pkg::MPP_SEL_MODE, 8'h01);
		wr.en = 1'b0;
		for (i = 0; i < 8; i++) begin
			tmr = i[0];
			#1;
			chk({shr_oe, shr_o, shr_pin}, {1'b1, tmr, tmr});
			step(1);
		end
		step(4);
		chk(pend, 2'b00);
		$display("test timer output done");
		// Long reset in mid-run after the ports were loaded
		wr_t(mpp_pkg::MPP_SEL_A_DIR, 8'hA5);
		wr_t(mpp_pkg::MPP_SEL_B_LAT, 8'h3C);
		wr.en = 1'b0;
		chk({a_drv.oe, b_q}, 16'hA53C);
		reset_n_in = 1'b0;
		step(101);
		chk_reset;
		reset_n_in = 1'b1;
		step(1);
		chk_reset;
		$display("test second reset done");
		print_verdict;
	end
endmodule
